// File: core/ssf_framer.sv
// Scan sequencer and space packet framer with an APB register slave.
// Assumes sampled data, time counters and anomaly events come in on the same clock.
// Function
// RULE1: Scan only while enable pin is one
// RULE2: Bus command also enables or disables scan
// RULE3: Running output high from start to last
// RULE4: Period from select and groups; invalid combos
// RULE5: Fast range high time from printed counts
// RULE6: Slow range counts are hundred times fast
// RULE7: Header, data, stamp, anomaly, check in order
// RULE8: Header version, flags, identifier, sequence flags
// RULE9: Header sequence count and data length
// RULE10: Data starts with digital channel fifteen
// RULE11: Analog from channel zero, MSB first
// RULE12: Data length from groups and modes
// RULE13: Stamp from mode, sync settings, size pins; code uses the size pins only
// RULE14: Anomaly flags from previous scan period
// RULE15: Anomaly octet only when enabled
// RULE16: CRC over complete packet
// RULE17: Check octets only when enabled
// RULE18: Simplified packets without header selectable
// RULE19: Same structure in all operating modes
// RULE20: Select zero simplified, one standard
// RULE21: Identifier from eleven static pins
// RULE22: Stamp size select encoding
// RULE23: Sequence count increments modulo 16384
// RULE24: Data length is octets minus one
// RULE25: CRC x16+x12+x5+1, ones preset, MSB first
`include "ssf_consts.svh"
module ssf_framer (
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst_b,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   // Static configuration pins
   input  wire logic          scan_enable_pin,
   input  wire logic [4:0]    scan_period_select,
   input  wire logic [1:0]    active_group_select,
   input  wire logic          clock_range_select,
   input  wire logic [1:0]    group01_conversion_mode,
   input  wire logic [1:0]    group2_conversion_mode,
   input  wire logic [1:0]    group3_conversion_mode,
   input  wire logic [1:0]    operating_mode_select,
   input  wire logic [2:0]    timestamp_size_select,
   input  wire logic          anomaly_field_enable,
   input  wire logic          check_field_enable,
   input  wire logic          header_include_select,
   input  wire logic [10:0]   process_id_pins,
   // Sampled data and time from the acquisition side
   input  wire logic [399:0]  sample_bits,
   input  wire logic [23:0]   free_run_count,
   input  wire logic [7:0]    strobe_count,
   input  wire logic [3:0]    anomaly_event,
   // Scan indication
   output logic               scan_running_out,
   output logic               config_invalid,
   // Octet stream toward the transmission interface
   output logic [7:0]         tx_data,
   output logic               tx_valid,
   output logic               tx_last,
   input  wire logic          tx_ready
);
   import ssf_pkg::*;

   // Pin synchronisers, first stage read only by the second
   logic [44:0] pin_s1_reg;            // First stage
   logic [44:0] pin_s2_reg;            // Second stage, used by logic
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1_reg <= 45'h0;
         pin_s2_reg <= 45'h0;
      end else begin
         pin_s1_reg <= {process_id_pins, header_include_select, check_field_enable,
                        anomaly_field_enable, timestamp_size_select, operating_mode_select,
                        group3_conversion_mode, group2_conversion_mode,
                        group01_conversion_mode, clock_range_select, active_group_select,
                        scan_period_select, scan_enable_pin, 11'h0};
         pin_s2_reg <= pin_s1_reg;
      end
   end
   logic [10:0] apid;                  // Process identifier
   logic        hdr_on, chk_on, ano_on, fast, en_pin;
   logic [2:0]  tos_sel;
   logic [1:0]  grp, m01, m2, m3;
   logic [4:0]  per_sel;
   assign apid    = pin_s2_reg[44:34];  // RULE21
   assign hdr_on  = pin_s2_reg[33];
   assign chk_on  = pin_s2_reg[32];
   assign ano_on  = pin_s2_reg[31];
   assign tos_sel = pin_s2_reg[30:28];
   assign m3      = pin_s2_reg[25:24];
   assign m2      = pin_s2_reg[23:22];
   assign m01     = pin_s2_reg[21:20];
   assign fast    = pin_s2_reg[19];
   assign grp     = pin_s2_reg[18:17];
   assign per_sel = pin_s2_reg[16:12];
   assign en_pin  = pin_s2_reg[11];

   // APB registers
   logic [31:0] ctrl_reg;              // Run command and sync settings
   logic [7:0]  anom_live_reg;         // Flags gathered in the current period
   logic [7:0]  anom_prev_reg;         // Flags of the previous period, sent in packets
   logic [13:0] seq_reg;               // Packet sequence count
   logic        apb_wr;
   assign apb_wr  = psel && penable && pwrite;
   assign pready  = 1'b1;              // Zero wait states
   assign pslverr = psel && penable && !(paddr == `SSF_CTRL_OFF || paddr == `SSF_STAT_OFF ||
                    paddr == `SSF_ANOM_OFF || paddr == `SSF_SEQ_OFF);
   // Control write, also the bus enable command
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) ctrl_reg <= `SSF_CTRL_RST;
      else if (apb_wr && paddr == `SSF_CTRL_OFF) ctrl_reg <= {29'h0, pwdata[2:0]}; // RULE2
   end
   logic scan_ok;                      // Both enables set
   assign scan_ok = en_pin && ctrl_reg[`SSF_CTRL_RUN_BIT]; // RULE1 RULE2

   // Read mux, registered
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) prdata <= 32'h0;
      else if (psel && !penable && !pwrite) begin
         case (paddr)
            `SSF_CTRL_OFF: prdata <= ctrl_reg;
            `SSF_STAT_OFF: prdata <= {29'h0, config_invalid, scan_running_out, scan_ok};
            `SSF_ANOM_OFF: prdata <= {24'h0, anom_prev_reg};
            `SSF_SEQ_OFF:  prdata <= {18'h0, seq_reg};
            default:       prdata <= 32'h0;
         endcase
      end
   end

   // Period and high time; counts are in master clock pulses
   logic [31:0] per_cnt, run_cnt, mul;
   logic [2:0]  ngrp;
   always_comb begin
      ngrp    = {1'b0, grp} + 3'h1;
      mul     = fast ? 32'd1 : `SSF_SLOW_MUL;                        // RULE6
      case (per_sel[4:2])                                          // Base multipliers 1,2.5,...
         3'h0: per_cnt = `SSF_BASE_PER;
         3'h1: per_cnt = 32'd80000;
         3'h2: per_cnt = 32'd160000;
         3'h3: per_cnt = 32'd320000;
         3'h4: per_cnt = 32'd800000;
         3'h5: per_cnt = 32'd1600000;
         3'h6: per_cnt = 32'd3200000;
         default: per_cnt = 32'd8000000;
      endcase
      run_cnt = (per_cnt >> 3) * {29'h0, ngrp} - `SSF_GAP_PULSES;  // RULE5
      per_cnt = (per_cnt >> per_sel[1:0]) * mul;                   // RULE4
      run_cnt = run_cnt * mul;                                     // RULE6
   end
   assign config_invalid = ({1'b0, per_sel[1:0]} + {1'b0, grp}) > 3'h3; // RULE4

   // Scan timer
   logic [31:0] tmr_reg;
   logic        scan_start;
   assign scan_start = scan_ok && !config_invalid && tmr_reg == 32'h0;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) tmr_reg <= 32'h0;
      else if (!scan_ok || config_invalid) tmr_reg <= 32'h0;       // RULE1
      else if (tmr_reg >= per_cnt - 32'h1) tmr_reg <= 32'h0;
      else tmr_reg <= tmr_reg + 32'h1;
   end
   // Running indication, high from start until last channel sampled
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) scan_running_out <= 1'b0;
      else if (scan_start) scan_running_out <= 1'b1;                // RULE3
      else if (!scan_ok || config_invalid || tmr_reg >= run_cnt) scan_running_out <= 1'b0; // RULE3
   end

   // Anomaly flags, set wins over period roll
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         anom_live_reg <= 8'h0;
         anom_prev_reg <= 8'h0;
      end else if (scan_start) begin
         anom_prev_reg <= (anom_live_reg | {4'h0, anomaly_event}) & `SSF_ANOM_MASK; // RULE14
         anom_live_reg <= 8'h0;
      end else begin
         anom_live_reg <= anom_live_reg | {4'h0, anomaly_event};
      end
   end

   // Field sizes in octets
   function automatic logic [6:0] data_octets(input logic [1:0] g, input logic [1:0] a,
                                              input logic [1:0] b, input logic [1:0] c);
      logic [9:0] bits;
      logic [9:0] b01;
      b01 = (a == 2'h3) ? ((g == 2'h0) ? 10'd16 : 10'd8) : 10'd96;
      case (g)
         2'h0:    bits = (a == 2'h3) ? 10'd16 : 10'd48;
         2'h1:    bits = b01;
         2'h2:    bits = b01 + ((b == 2'h3) ? 10'd8 : 10'd96);
         default: bits = b01 + ((b == 2'h3) ? 10'd8 : 10'd96) + ((c == 2'h3) ? 10'd16 : 10'd192);
      endcase
      data_octets = 7'((bits + 10'd16) >> 3);                      // RULE12
   endfunction
   function automatic logic [2:0] tos_octets(input logic [2:0] s);
      case (s)                                                     // RULE22
         3'h1: tos_octets = 3'h1;
         3'h2: tos_octets = 3'h2;
         3'h4: tos_octets = 3'h3;
         3'h5: tos_octets = 3'h3;
         3'h7: tos_octets = 3'h4;
         default: tos_octets = 3'h0;
      endcase
   endfunction
   logic [6:0] n_data;
   logic [2:0] n_tos;
   logic [7:0] pkt_len;
   assign n_data  = data_octets(grp, m01, m2, m3);
   assign n_tos   = tos_octets(tos_sel);                          // RULE13
   assign pkt_len = {1'b0, n_data} + {5'h0, n_tos} + {7'h0, ano_on} + {6'h0, chk_on, 1'b0}
                    - 8'h1;                                        // RULE24

   // Snapshot of time stamp octets, Byte 0 sent last; content set by the size select alone
   logic [31:0] tos_word;
   always_comb begin
      case (tos_sel)
         3'h1:    tos_word = {24'h0, strobe_count};
         3'h2:    tos_word = {16'h0, free_run_count[15:0]};
         3'h4:    tos_word = {8'h0, free_run_count};
         3'h5:    tos_word = {8'h0, strobe_count, free_run_count[15:0]};
         3'h7:    tos_word = {strobe_count, free_run_count};
         default: tos_word = 32'h0;
      endcase
   end

   // Framer state machine, same layout in every operating mode
   ssf_state_t  st_reg;
   logic [6:0]  idx_reg;               // Octet index within field
   logic [399:0] smp_reg;              // Latched sample bits, digital ch15 at MSB
   logic [47:0] hdr_reg;
   logic [31:0] tos_reg;
   logic [15:0] crc_reg;
   logic        fire;
   assign fire = tx_valid && tx_ready;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_reg  <= SSF_IDLE;
         idx_reg <= 7'h0;
         smp_reg <= 400'h0;
         hdr_reg <= 48'h0;
         tos_reg <= 32'h0;
      end else begin
         case (st_reg)
            SSF_IDLE: if (scan_start) begin                        // RULE19
               smp_reg <= sample_bits;                             // RULE10 RULE11
               hdr_reg <= {`SSF_HDR_VER, 2'h0, apid, `SSF_HDR_SEQF, seq_reg, 8'h0, pkt_len}; // RULE8 RULE9
               tos_reg <= tos_word << {(3'h4 - n_tos), 3'h0};
               idx_reg <= 7'h0;
               st_reg  <= hdr_on ? SSF_HDR : SSF_DATA;             // RULE18 RULE20
            end
            SSF_HDR: if (fire) begin                               // RULE7
               hdr_reg <= hdr_reg << 8;
               idx_reg <= (idx_reg == 7'h5) ? 7'h0 : idx_reg + 7'h1;
               if (idx_reg == 7'h5) st_reg <= SSF_DATA;
            end
            SSF_DATA: if (fire) begin
               smp_reg <= smp_reg << 8;
               idx_reg <= (idx_reg == n_data - 7'h1) ? 7'h0 : idx_reg + 7'h1;
               if (idx_reg == n_data - 7'h1)
                  st_reg <= (n_tos != 3'h0) ? SSF_TOS : ano_on ? SSF_ANOM :
                            chk_on ? SSF_CRC : SSF_IDLE;
            end
            SSF_TOS: if (fire) begin
               tos_reg <= tos_reg << 8;
               idx_reg <= (idx_reg == {4'h0, n_tos} - 7'h1) ? 7'h0 : idx_reg + 7'h1;
               if (idx_reg == {4'h0, n_tos} - 7'h1)
                  st_reg <= ano_on ? SSF_ANOM : chk_on ? SSF_CRC : SSF_IDLE; // RULE15
            end
            SSF_ANOM: if (fire) st_reg <= chk_on ? SSF_CRC : SSF_IDLE; // RULE17
            SSF_CRC: if (fire) begin
               idx_reg <= (idx_reg == 7'h1) ? 7'h0 : idx_reg + 7'h1;
               if (idx_reg == 7'h1) st_reg <= SSF_IDLE;
            end
            default: st_reg <= SSF_IDLE;
         endcase
      end
   end

   // Current octet, combinational handshake
   always_comb begin
      case (st_reg)
         SSF_HDR:  tx_data = hdr_reg[47:40];
         SSF_DATA: tx_data = smp_reg[399:392];
         SSF_TOS:  tx_data = tos_reg[31:24];
         SSF_ANOM: tx_data = anom_prev_reg;
         SSF_CRC:  tx_data = (idx_reg == 7'h0) ? crc_reg[15:8] : crc_reg[7:0];
         default:  tx_data = 8'h0;
      endcase
   end
   assign tx_valid = st_reg != SSF_IDLE;
   assign tx_last  = fire && ((st_reg == SSF_CRC && idx_reg == 7'h1) ||
                     (!chk_on && ((st_reg == SSF_ANOM) ||
                     (!ano_on && st_reg == SSF_TOS && idx_reg == {4'h0, n_tos} - 7'h1) ||
                     (!ano_on && n_tos == 3'h0 && st_reg == SSF_DATA && idx_reg == n_data - 7'h1))));

   // CRC one octet per accepted transfer outside the check octets, MSB first
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = (r[15] ^ d[i]) ? ((r << 1) ^ `SSF_CRC_POLY) : (r << 1);
      end
      crc_byte = r;
   endfunction
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) crc_reg <= `SSF_CRC_INIT;
      else if (st_reg == SSF_IDLE) crc_reg <= `SSF_CRC_INIT;       // RULE25
      else if (fire && st_reg != SSF_CRC) crc_reg <= crc_byte(crc_reg, tx_data); // RULE16
   end

   // Sequence count per emitted packet
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) seq_reg <= 14'h0;
      else if (tx_last) seq_reg <= seq_reg + 14'h1;                 // RULE23
   end

   // Checks
   property p_run_needs_en;
      @(posedge clock) disable iff (!rst_b) $rose(scan_running_out) |-> $past(scan_ok);
   endproperty
   a_run_needs_en: assert property (p_run_needs_en) else $error("run without enable"); // RULE1
   property p_invalid_stops;
      @(posedge clock) disable iff (!rst_b)
         config_invalid |=> !scan_running_out && tmr_reg == 32'h0;
   endproperty
   a_invalid_stops: assert property (p_invalid_stops) else $error("scan on invalid"); // RULE4
   property p_start_raises;
      @(posedge clock) disable iff (!rst_b) scan_start |=> scan_running_out;
   endproperty
   a_start_raises: assert property (p_start_raises) else $error("run not raised"); // RULE3
   property p_seq_step;
      @(posedge clock) disable iff (!rst_b) tx_last |=> seq_reg == $past(seq_reg) + 14'h1;
   endproperty
   a_seq_step: assert property (p_seq_step) else $error("sequence step wrong"); // RULE23
   property p_hdr_first;
      @(posedge clock) disable iff (!rst_b)
         (st_reg == SSF_IDLE && scan_start && hdr_on) |=> st_reg == SSF_HDR;
   endproperty
   a_hdr_first: assert property (p_hdr_first) else $error("header not first"); // RULE20
   property p_no_hdr;
      @(posedge clock) disable iff (!rst_b)
         (st_reg == SSF_IDLE && scan_start && !hdr_on) |=> st_reg == SSF_DATA;
   endproperty
   a_no_hdr: assert property (p_no_hdr) else $error("simplified wrong"); // RULE18
   property p_no_anom;
      @(posedge clock) disable iff (!rst_b) !ano_on |-> st_reg != SSF_ANOM;
   endproperty
   a_no_anom: assert property (p_no_anom) else $error("anomaly sent"); // RULE15
   property p_no_crc;
      @(posedge clock) disable iff (!rst_b) !chk_on |-> st_reg != SSF_CRC;
   endproperty
   a_no_crc: assert property (p_no_crc) else $error("check sent"); // RULE17
   property p_ver;
      @(posedge clock) disable iff (!rst_b) st_reg == SSF_HDR && idx_reg == 7'h0 |->
         tx_data[7:3] == 5'h0;
   endproperty
   a_ver: assert property (p_ver) else $error("version bits wrong"); // RULE8
endmodule // ssf_framer

// File: core/ssf_consts.svh
// Constants for the scan sequencer and packet framer: APB offsets, field positions, timing.
// Assumes inclusion by bare name from the core module and the bench.
`ifndef SSF_CONSTS_SVH
`define SSF_CONSTS_SVH
// APB register byte offsets
`define SSF_CTRL_OFF      12'h000
`define SSF_STAT_OFF      12'h004
`define SSF_ANOM_OFF      12'h008
`define SSF_SEQ_OFF       12'h00c
// Control register fields and reset value
`define SSF_CTRL_RUN_BIT  0
`define SSF_CTRL_SYNC_BIT 1
`define SSF_CTRL_SAV_BIT  2
`define SSF_CTRL_RST      32'h00000001
// Header fixed values
`define SSF_HDR_VER       3'h0
`define SSF_HDR_SEQF      2'h3
// Time figures at the fast range (master clock pulses, as printed per base)
`define SSF_CLK_NS        100
`define SSF_BASE_PER      32'd32000
`define SSF_BASE_RUN      32'd3995
`define SSF_GAP_PULSES    32'd5
`define SSF_SLOW_MUL      32'd100
// CRC preset and polynomial
`define SSF_CRC_INIT      16'hffff
`define SSF_CRC_POLY      16'h1021
// Anomaly bits in use
`define SSF_ANOM_MASK     8'h0f
`endif

// File: core/ssf_pkg.sv
// Types shared by the scan sequencer and packet framer.
// Assumes nothing beyond the constants header.
package ssf_pkg;
   // Framer states, one-hot
   typedef enum logic [5:0] {
      SSF_IDLE = 6'b000001,
      SSF_HDR  = 6'b000010,
      SSF_DATA = 6'b000100,
      SSF_TOS  = 6'b001000,
      SSF_ANOM = 6'b010000,
      SSF_CRC  = 6'b100000
   } ssf_state_t;
endpackage : ssf_pkg

// File: bench/ssf_sink.sv
// Receiver model for the framer's octet stream, with an optional stall rhythm.
// Assumes the framer's clock and its active-low reset.
module ssf_sink (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_b,
   // Octet stream from the framer
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   input  wire logic       tx_last,
   output logic            tx_ready,
   // Bench control
   input  wire logic       stall_en
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] got[$];  // Last flag and octet, oldest first
   logic [1:0] phase;   // Stall rhythm counter
   // Take an octet at each edge with valid and ready high
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tx_ready <= 1'b0;
         phase    <= 2'h0;
      end else begin
         phase    <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
         // A slow receiver drops ready one cycle in three
         tx_ready <= !(stall_en && phase == 2'h1);
         if (tx_valid && tx_ready) got.push_back({tx_last, tx_data});
      end
   end
endmodule // ssf_sink

// File: bench/ssf_framer_test.sv
// Self-checking bench for the scan sequencer and packet framer.
// Assumes the constants header and a receiver model beside the design.
`include "ssf_consts.svh"
module ssf_framer_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic          clock, rst_b, psel, penable, pwrite, pready, pslverr;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rd;
   logic          scan_enable_pin, clock_range_select, anomaly_field_enable;
   logic          check_field_enable, header_include_select, scan_running_out;
   logic          config_invalid, tx_valid, tx_last, tx_ready, stall_en, er;
   logic [4:0]    scan_period_select;
   logic [1:0]    active_group_select, operating_mode_select;
   logic [1:0]    group01_conversion_mode, group2_conversion_mode, group3_conversion_mode;
   logic [2:0]    timestamp_size_select;
   logic [10:0]   process_id_pins;
   logic [399:0]  sample_bits;
   logic [23:0]   free_run_count;
   logic [7:0]    strobe_count, tx_data;
   logic [3:0]    anomaly_event;
   logic [7:0]    exp_q[$];  // Expected packet octets
   logic [15:0]   crc;       // Running check value
   int            bad_count, checks_done, cycles, n, hi, per;

   ssf_framer DUT (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .scan_enable_pin, .scan_period_select, .active_group_select,
      .clock_range_select, .group01_conversion_mode, .group2_conversion_mode,
      .group3_conversion_mode, .operating_mode_select, .timestamp_size_select,
      .anomaly_field_enable, .check_field_enable, .header_include_select,
      .process_id_pins, .sample_bits, .free_run_count, .strobe_count, .anomaly_event,
      .scan_running_out, .config_invalid, .tx_data, .tx_valid, .tx_last, .tx_ready);
   ssf_sink sink (.clock, .rst_b, .tx_data, .tx_valid, .tx_last, .tx_ready, .stall_en);

   // Clock and a cycle ceiling against hangs
   always #50 clock = ~clock;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      if (bad_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, want);
      end
   endtask

   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clock);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Edges until the running output rises, lim if it never does
   task automatic wait_rise(input int lim, output int k);
      logic was;
      was = scan_running_out;
      for (k = 0; k < lim; k++) begin
         @(posedge clock);
         if (scan_running_out === 1'b1 && was !== 1'b1) break;
         was = scan_running_out;
      end
   endtask

   // High time and period from a rise; pulses an anomaly mid-scan
   task automatic measure(output int h, output int p);
      int m;
      h = 1;
      while (h < 20000) begin
         @(posedge clock);
         anomaly_event <= (h == 100) ? 4'h5 : 4'h0;
         if (scan_running_out !== 1'b1) break;
         h++;
      end
      wait_rise(20000, m);
      p = h + m + 1;
   endtask

   // Append an octet, folding it into the check value MSB first
   task automatic add(input logic [7:0] b);
      exp_q.push_back(b);
      for (int i = 7; i >= 0; i--)
         crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[i]) ? `SSF_CRC_POLY : 16'h0000);
   endtask

   // Expected packet from the pins as they stand now
   task automatic build(input logic [13:0] seq, input logic [7:0] anom);
      logic [31:0] w;
      logic [15:0] len, c;
      int nt, nd;
      exp_q = {};
      crc = `SSF_CRC_INIT;
      nt = 0;
      w = 32'h0;
      // Digital 16 bits plus half or all of the first groups
      nd = (active_group_select == 2'h0) ? 8 : 14;
      case (timestamp_size_select)
         3'h1: begin w = {strobe_count, 24'h0}; nt = 1; end
         3'h2: begin w = {free_run_count[15:0], 16'h0}; nt = 2; end
         3'h4: begin w = {free_run_count, 8'h0}; nt = 3; end
         3'h5: begin w = {strobe_count, free_run_count[15:0], 8'h0}; nt = 3; end
         3'h7: begin w = {strobe_count, free_run_count}; nt = 4; end
         default: nt = 0;
      endcase
      len = 16'(nd + nt + 32'(anomaly_field_enable) + 2 * 32'(check_field_enable) - 1);
      if (header_include_select) begin
         add({`SSF_HDR_VER, 2'b00, process_id_pins[10:8]});
         add(process_id_pins[7:0]);
         add({`SSF_HDR_SEQF, seq[13:8]});
         add(seq[7:0]);
         add(len[15:8]);
         add(len[7:0]);
      end
      for (int k = 0; k < nd; k++) add(sample_bits[399 - 8 * k -: 8]);
      for (int k = 0; k < nt; k++) add(w[31 - 8 * k -: 8]);
      if (anomaly_field_enable) add(anom);
      c = crc;
      if (check_field_enable) begin
         add(c[15:8]);
         add(c[7:0]);
      end
   endtask

   // Octets in order, last flag only on the final one
   task automatic check_pkt();
      logic [8:0] g;
      for (int k = 0; k < exp_q.size(); k++) begin
         while (sink.got.size() == 0) @(posedge clock);
         g = sink.got.pop_front();
         chk({23'h0, g}, {23'h0, k == exp_q.size() - 1, exp_q[k]});
      end
   endtask

   initial begin
      clock = 1'b0; rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; stall_en = 1'b1; anomaly_event = 4'h0;
      bad_count = 0; checks_done = 0; cycles = 0;
      scan_enable_pin = 1'b0; scan_period_select = 5'h03; active_group_select = 2'h0;
      clock_range_select = 1'b1; group01_conversion_mode = 2'h0;
      group2_conversion_mode = 2'h1; group3_conversion_mode = 2'h0;
      operating_mode_select = 2'h0; timestamp_size_select = 3'h7;
      anomaly_field_enable = 1'b1; check_field_enable = 1'b1;
      header_include_select = 1'b1; process_id_pins = 11'h5a3;
      free_run_count = 24'h3c5a96; strobe_count = 8'h7e;
      for (int i = 0; i < 50; i++) sample_bits[8 * i +: 8] = 8'(i * 37) ^ 8'h3c;
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      // Reset values and an unmapped place
      apb(1'b0, `SSF_CTRL_OFF, 32'h0);
      chk(rd, `SSF_CTRL_RST);
      apb(1'b0, `SSF_SEQ_OFF, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
      wait_rise(200, n);
      chk(32'(n), 32'd200);
      scan_enable_pin <= 1'b1;
      wait_rise(200, n);
      measure(hi, per);
      chk(32'(hi), `SSF_BASE_RUN);
      chk(32'(per), `SSF_BASE_PER >> 3);
      build(14'h0, 8'h00);
      check_pkt();
      build(14'h1, 8'h05);
      check_pkt();
      apb(1'b0, `SSF_ANOM_OFF, 32'h0);
      chk(rd, 32'h5);
      // Two groups, short stamp, no header, anomaly or check octets
      scan_period_select <= 5'h02;
      active_group_select <= 2'h1;
      header_include_select <= 1'b0;
      check_field_enable <= 1'b0;
      anomaly_field_enable <= 1'b0;
      timestamp_size_select <= 3'h2;
      operating_mode_select <= 2'h2;
      wait_rise(9000, n);
      build(14'h2, 8'h00);
      measure(hi, per);
      chk(32'(hi), 32'd7995);
      chk(32'(per), 32'd8000);
      check_pkt();
      // Invalid combination stops the scan
      active_group_select <= 2'h3;
      repeat (3) @(posedge clock);
      chk({31'h0, config_invalid}, 32'h1);
      wait_rise(9000, n);
      chk(32'(n), 32'd9000);
      // Bus command stops the scan before the groups turn valid again
      apb(1'b1, `SSF_CTRL_OFF, 32'h0);
      active_group_select <= 2'h1;
      wait_rise(9000, n);
      chk(32'(n), 32'd9000);
      apb(1'b1, `SSF_CTRL_OFF, 32'h1);
      wait_rise(9000, n);
      chk(32'(n < 9000), 32'h1);
      scan_enable_pin <= 1'b0;
      wait_rise(9000, n);
      chk(32'(n), 32'd9000);
      // Slow range still high 5000 cycles after the rise
      clock_range_select <= 1'b0;
      scan_enable_pin <= 1'b1;
      wait_rise(9000, n);
      repeat (5000) @(posedge clock);
      chk({31'h0, scan_running_out}, 32'h1);
      apb(1'b0, `SSF_STAT_OFF, 32'h0);
      chk(rd, 32'h3);
      end_of_test();
   end
endmodule // ssf_framer_test
